/* File: verilog/ddsl_pkg.sv */
// constants and types shared by both ends of the serial word link
package ddsl_pkg;
    // word layout
    localparam int WORD_BITS  = 16;
    localparam int ADDR_POS   = 15;
    localparam int IGNORE_POS = 14;
    localparam int SD_POS     = 13;
    localparam int ZERO_POS   = 12;
    localparam int CODE_BITS  = 12;
    localparam int CODE_MSB   = 11;

    typedef logic [WORD_BITS-1:0] ddsl_word_type;
    typedef logic [CODE_BITS-1:0] ddsl_code_type;
    typedef logic [3:0]           ddsl_count_type;

    // reset values and counts
    localparam ddsl_code_type  MIDSCALE_CODE = 12'h800;
    localparam ddsl_word_type  SHIFT_CLEAR   = 16'h0000;
    localparam ddsl_count_type COUNT_FIRST   = 4'h0;
    localparam ddsl_count_type COUNT_LAST    = 4'hf;
    localparam ddsl_count_type COUNT_STEP    = 4'h1;

    // host serial clock timing
    localparam int MCLK_PERIOD_NS = 25;
    localparam int SCLK_HALF_NS   = 50;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam logic [3:0] HALF_RELOAD = 4'(SCLK_HALF_CYC - 1);
    localparam logic [3:0] TIMER_ZERO  = 4'h0;
    localparam logic [3:0] TIMER_STEP  = 4'h1;
endpackage : ddsl_pkg

/* File: verilog/ddsl_link_if.sv */
// three-wire link between host controller and converter
`timescale 1ns/1ps
interface ddsl_link_if;
    logic frame_sel_n;
    logic sclk;
    logic serial_in_line;

    // host drives every wire
    modport host_end
    (
        output frame_sel_n,
        output sclk,
        output serial_in_line
    );

    // device only listens
    modport dev_end
    (
        input frame_sel_n,
        input sclk,
        input serial_in_line
    );
endinterface : ddsl_link_if

/* File: verilog/ddsl_edge_det.sv */
// edge detector for a level already synchronous to the clock
`timescale 1ns/1ps
module ddsl_edge_det
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    // level and its edges
    input  wire logic level_in,
    output logic      rise_out,
    output logic      fall_out
);
    logic prev_reg;
    logic prev_next;

    // previous level
    always_comb
    begin
        prev_next = level_in;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            prev_reg <= RESET_LEVEL;
        else
            prev_reg <= prev_next;
    end

    // edges against previous level
    assign rise_out = level_in & ~prev_reg;
    assign fall_out = ~level_in & prev_reg;
endmodule : ddsl_edge_det

/* File: verilog/ddsl_device.sv */
// converter end: serial word loader, channel registers, shutdown control
//
// Contract
// - sample data only on serial clock rise
// - words arrive msb first, first bit top
// - frame starts on frame select falling edge
// - sixteenth edge loads without frame select rising
// - host raises frame select before next frame
// - addr, ignored, shutdown, zero, twelve code bits
// - address zero channel a, one channel b
// - shutdown bit stops both channels together
// - shutdown floats both outputs and reference
// - only matching address clears shutdown
// - sixteenth edge loads addressed channel register
// - reset clears shifter, channels to midscale
// - codes still accepted during shutdown
`timescale 1ns/1ps
module ddsl_device
    import ddsl_pkg::*;
(
    // clock and reset
    input  wire logic              mclk_in,
    input  wire logic              reset_n_in,
    // link
    ddsl_link_if.dev_end           link,
    // channel codes
    output ddsl_pkg::ddsl_code_type chan_a_code_out,
    output ddsl_pkg::ddsl_code_type chan_b_code_out,
    output logic                   chan_a_update_out,
    output logic                   chan_b_update_out,
    // analog enables, low while driving
    output logic                   chan_a_oe_n_out,
    output logic                   chan_b_oe_n_out,
    output logic                   bz_ref_oe_n_out,
    // status
    output logic                   power_down_out,
    output logic                   word_done_out,
    output logic                   zero_bit_err_out
);
    import ddsl_pkg::*;

    typedef enum logic [1:0] {DDSL_IDLE, DDSL_SHIFT, DDSL_DONE} ddsl_state_type;

    ddsl_state_type state_reg;
    ddsl_state_type state_next;
    ddsl_word_type  input_shifter_reg;
    ddsl_word_type  input_shifter_next;
    ddsl_count_type count_reg;
    ddsl_count_type count_next;
    ddsl_code_type  chan_a_reg;
    ddsl_code_type  chan_a_next;
    ddsl_code_type  chan_b_reg;
    ddsl_code_type  chan_b_next;
    logic           upd_a_reg;
    logic           upd_a_next;
    logic           upd_b_reg;
    logic           upd_b_next;
    logic           power_down_reg;
    logic           power_down_next;
    logic           pd_addr_reg;
    logic           pd_addr_next;
    logic           done_reg;
    logic           done_next;
    logic           zero_err_reg;
    logic           zero_err_next;

    logic           sclk_rise;
    logic           frame_fall;
    logic           frame_rise;
    ddsl_word_type  shifted_word;
    logic           load_word;
    logic           channel_addr_bit;
    logic           power_down_bit;
    ddsl_code_type  code_bits;

    // serial clock rising edges
    ddsl_edge_det #(.RESET_LEVEL(1'b0)) u_sclk_edge
    (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .level_in   (link.sclk),
        .rise_out   (sclk_rise),
        .fall_out   ()
    );

    // frame select edges; low at reset so a real high is needed first
    ddsl_edge_det #(.RESET_LEVEL(1'b0)) u_frame_edge
    (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .level_in   (link.frame_sel_n),
        .rise_out   (frame_rise),
        .fall_out   (frame_fall)
    );

    // word as it stands after this bit, first bit ends up on top
    assign shifted_word = {input_shifter_reg[WORD_BITS-2:0], link.serial_in_line};
    assign load_word    = (state_reg == DDSL_SHIFT) && sclk_rise && !link.frame_sel_n
                          && (count_reg == COUNT_LAST);

    // word fields
    assign channel_addr_bit = shifted_word[ADDR_POS];
    assign power_down_bit   = shifted_word[SD_POS];
    assign code_bits        = shifted_word[CODE_MSB:0];

    // framing and shifting
    always_comb
    begin
        state_next         = state_reg;
        input_shifter_next = input_shifter_reg;
        count_next         = count_reg;
        unique case (state_reg)
            DDSL_IDLE:
            begin
                if (frame_fall)
                begin
                    state_next = DDSL_SHIFT;
                    count_next = COUNT_FIRST;
                end
            end
            DDSL_SHIFT:
            begin
                if (frame_rise)
                begin
                    state_next = DDSL_IDLE; // short frame dropped
                end
                else if (sclk_rise)
                begin
                    input_shifter_next = shifted_word;
                    count_next         = count_reg + COUNT_STEP;
                    if (count_reg == COUNT_LAST)
                        state_next = DDSL_DONE;
                end
            end
            DDSL_DONE:
            begin
                if (frame_rise)
                    state_next = DDSL_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_reg         <= DDSL_IDLE;
            input_shifter_reg <= SHIFT_CLEAR;
            count_reg         <= COUNT_FIRST;
        end
        else
        begin
            state_reg         <= state_next;
            input_shifter_reg <= input_shifter_next;
            count_reg         <= count_next;
        end
    end

    // channel registers, loaded even while powered down
    always_comb
    begin
        chan_a_next   = chan_a_reg;
        chan_b_next   = chan_b_reg;
        upd_a_next    = 1'b0;
        upd_b_next    = 1'b0;
        done_next     = load_word;
        zero_err_next = load_word && shifted_word[ZERO_POS];
        if (load_word)
        begin
            if (channel_addr_bit)
            begin
                chan_b_next = code_bits;
                upd_b_next  = 1'b1;
            end
            else
            begin
                chan_a_next = code_bits;
                upd_a_next  = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            chan_a_reg   <= MIDSCALE_CODE;
            chan_b_reg   <= MIDSCALE_CODE;
            upd_a_reg    <= 1'b0;
            upd_b_reg    <= 1'b0;
            done_reg     <= 1'b0;
            zero_err_reg <= 1'b0;
        end
        else
        begin
            chan_a_reg   <= chan_a_next;
            chan_b_reg   <= chan_b_next;
            upd_a_reg    <= upd_a_next;
            upd_b_reg    <= upd_b_next;
            done_reg     <= done_next;
            zero_err_reg <= zero_err_next;
        end
    end

    // shutdown state and the address that owns it
    always_comb
    begin
        power_down_next = power_down_reg;
        pd_addr_next    = pd_addr_reg;
        if (load_word)
        begin
            if (power_down_bit)
            begin
                power_down_next = 1'b1;
                pd_addr_next    = channel_addr_bit;
            end
            else if (power_down_reg && (channel_addr_bit == pd_addr_reg))
            begin
                power_down_next = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            power_down_reg <= 1'b0;
            pd_addr_reg    <= 1'b0;
        end
        else
        begin
            power_down_reg <= power_down_next;
            pd_addr_reg    <= pd_addr_next;
        end
    end

    // outputs straight from registers
    assign chan_a_code_out   = chan_a_reg;
    assign chan_b_code_out   = chan_b_reg;
    assign chan_a_update_out = upd_a_reg;
    assign chan_b_update_out = upd_b_reg;
    assign chan_a_oe_n_out   = power_down_reg;
    assign chan_b_oe_n_out   = power_down_reg;
    assign bz_ref_oe_n_out   = power_down_reg;
    assign power_down_out    = power_down_reg;
    assign word_done_out     = done_reg;
    assign zero_bit_err_out  = zero_err_reg;
endmodule : ddsl_device

/* File: verilog/ddsl_host.sv */
// host end: sends one 16-bit word per request over the three-wire link
`timescale 1ns/1ps
module ddsl_host
    import ddsl_pkg::*;
(
    // clock and reset
    input  wire logic               mclk_in,
    input  wire logic               reset_n_in,
    // request
    input  wire logic               req_valid_in,
    input  wire logic               channel_addr_bit_in,
    input  wire logic               power_down_bit_in,
    input  wire ddsl_pkg::ddsl_code_type code_bits_in,
    output logic                    ready_out,
    output logic                    done_out,
    // link
    ddsl_link_if.host_end           link
);
    import ddsl_pkg::*;

    typedef enum logic [1:0] {DDSH_IDLE, DDSH_LOW, DDSH_HIGH, DDSH_END} ddsh_state_type;

    ddsh_state_type state_reg;
    ddsh_state_type state_next;
    ddsl_word_type  word_reg;
    ddsl_word_type  word_next;
    ddsl_count_type bit_reg;
    ddsl_count_type bit_next;
    logic [3:0]     timer_reg;
    logic [3:0]     timer_next;
    logic           cs_n_reg;
    logic           cs_n_next;
    logic           sclk_reg;
    logic           sclk_next;
    logic           sdo_reg;
    logic           sdo_next;
    logic           done_reg;
    logic           done_next;
    logic           tick;

    // half-period enable from the divider
    assign tick = (timer_reg == TIMER_ZERO);

    // sequencer: data changes while clock is low, msb first, zero bit forced
    always_comb
    begin
        state_next = state_reg;
        word_next  = word_reg;
        bit_next   = bit_reg;
        timer_next = tick ? HALF_RELOAD : timer_reg - TIMER_STEP;
        cs_n_next  = cs_n_reg;
        sclk_next  = sclk_reg;
        sdo_next   = sdo_reg;
        done_next  = 1'b0;
        unique case (state_reg)
            DDSH_IDLE:
            begin
                timer_next = HALF_RELOAD;
                if (req_valid_in)
                begin
                    word_next = {channel_addr_bit_in, 1'b0, power_down_bit_in, 1'b0,
                                 code_bits_in};
                    bit_next   = COUNT_LAST;
                    cs_n_next  = 1'b0;
                    sdo_next   = channel_addr_bit_in;
                    state_next = DDSH_LOW;
                end
            end
            DDSH_LOW:
            begin
                if (tick)
                begin
                    sclk_next  = 1'b1;
                    state_next = DDSH_HIGH;
                end
            end
            DDSH_HIGH:
            begin
                if (tick)
                begin
                    sclk_next = 1'b0;
                    if (bit_reg == COUNT_FIRST)
                    begin
                        cs_n_next  = 1'b1;
                        state_next = DDSH_END;
                    end
                    else
                    begin
                        bit_next   = bit_reg - COUNT_STEP;
                        sdo_next   = word_reg[bit_reg - COUNT_STEP];
                        state_next = DDSH_LOW;
                    end
                end
            end
            DDSH_END:
            begin
                if (tick)
                begin
                    done_next  = 1'b1;
                    state_next = DDSH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_reg <= DDSH_IDLE;
            word_reg  <= SHIFT_CLEAR;
            bit_reg   <= COUNT_FIRST;
            timer_reg <= TIMER_ZERO;
            cs_n_reg  <= 1'b1;
            sclk_reg  <= 1'b0;
            sdo_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            word_reg  <= word_next;
            bit_reg   <= bit_next;
            timer_reg <= timer_next;
            cs_n_reg  <= cs_n_next;
            sclk_reg  <= sclk_next;
            sdo_reg   <= sdo_next;
            done_reg  <= done_next;
        end
    end

    // outputs from registers
    assign link.frame_sel_n    = cs_n_reg;
    assign link.sclk           = sclk_reg;
    assign link.serial_in_line = sdo_reg;
    assign ready_out           = (state_reg == DDSH_IDLE);
    assign done_out            = done_reg;
endmodule : ddsl_host

/* File: bench/ddsl_monitor.sv */
// assertions on the link and the converter end
`timescale 1ns/1ps
module ddsl_monitor
(
    // clock and reset
    input wire logic                    mclk_in,
    input wire logic                    reset_n_in,
    // link wires
    input wire logic                    frame_sel_n,
    input wire logic                    sclk,
    input wire logic                    serial_in_line,
    // converter end outputs
    input wire ddsl_pkg::ddsl_code_type chan_a_code_out,
    input wire ddsl_pkg::ddsl_code_type chan_b_code_out,
    input wire logic                    chan_a_update_out,
    input wire logic                    chan_b_update_out,
    input wire logic                    chan_a_oe_n_out,
    input wire logic                    chan_b_oe_n_out,
    input wire logic                    bz_ref_oe_n_out,
    input wire logic                    power_down_out,
    input wire logic                    word_done_out,
    input wire logic                    zero_bit_err_out
);
    import ddsl_pkg::*;

    logic          fs_reg;
    logic          sk_reg;
    logic          sda_reg;
    logic [4:0]    cnt_reg;
    ddsl_word_type sh_reg;
    logic          last;
    ddsl_word_type word;

    // sixteenth rise of a frame and the word it completes
    assign last = sclk && !sk_reg && !frame_sel_n && cnt_reg == 5'h0f;
    assign word = {sh_reg[14:0], serial_in_line};

    // frame tracker and recorded shutdown address
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            fs_reg  <= 1'b0;
            sk_reg  <= 1'b0;
            sda_reg <= 1'b0;
            cnt_reg <= 5'h10;
            sh_reg  <= 16'h0000;
        end
        else
        begin
            fs_reg <= frame_sel_n;
            sk_reg <= sclk;
            if (last && word[13])
                sda_reg <= word[15];
            if (fs_reg && !frame_sel_n)
                cnt_reg <= 5'h00;
            else if (frame_sel_n)
                cnt_reg <= 5'h10;
            else if (sclk && !sk_reg && cnt_reg < 5'h10)
            begin
                cnt_reg <= cnt_reg + 5'h01;
                sh_reg  <= word;
            end
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence word_in;
        last;
    endsequence
    sequence sd_clear_word;
        last && !word[13] && power_down_out;
    endsequence

    done_after_16_a:
        assert property (word_in |=> word_done_out) else $error("word not loaded");
    no_stray_load_a:
        assert property (!last |=> !word_done_out && !chan_a_update_out && !chan_b_update_out)
        else $error("load without sixteenth rise");
    chan_a_load_a:
        assert property (word_in ##0 !word[15] |=> chan_a_update_out && !chan_b_update_out
            && chan_a_code_out == sh_reg[11:0]) else $error("channel a load wrong");
    chan_b_load_a:
        assert property (word_in ##0 word[15] |=> chan_b_update_out && !chan_a_update_out
            && chan_b_code_out == sh_reg[11:0]) else $error("channel b load wrong");
    codes_hold_a:
        assert property (!last |=> $stable(chan_a_code_out) && $stable(chan_b_code_out)
            && $stable(power_down_out)) else $error("state changed without word");
    sd_set_a:
        assert property (word_in ##0 word[13] |=> power_down_out) else $error("no shutdown");
    sd_keep_a:
        assert property (sd_clear_word ##0 word[15] != sda_reg |=> power_down_out)
        else $error("shutdown cleared by other address");
    sd_clear_a:
        assert property (sd_clear_word ##0 word[15] == sda_reg |=> !power_down_out)
        else $error("shutdown not cleared");
    outputs_float_a:
        assert property ({chan_a_oe_n_out, chan_b_oe_n_out, bz_ref_oe_n_out}
            == {3{power_down_out}}) else $error("output enables wrong");
    zero_bit_a:
        assert property (word_in |=> zero_bit_err_out == sh_reg[12]) else $error("bit 12 flag");
endmodule : ddsl_monitor

/* File: bench/dual_dac_serial_word_loader_test.sv */
// testbench joining host and converter ends over the link
`timescale 1ns/1ps
module dual_dac_serial_word_loader_test;
    import ddsl_pkg::*;

    logic          mclk_in;
    logic          reset_n_in;
    logic          req_valid;
    logic          req_addr;
    logic          req_pd;
    ddsl_code_type req_code;
    logic          ready;
    logic          done;
    ddsl_code_type a_code;
    ddsl_code_type b_code;
    ddsl_code_type c2a;
    ddsl_code_type c2b;
    logic          a_upd;
    logic          b_upd;
    logic          a_oe;
    logic          b_oe;
    logic          bz_oe;
    logic          pd;
    logic          wdone;
    logic          err;
    logic          wd2;
    logic          er2;
    ddsl_word_type ww;
    int            n_fail;
    int            samples_checked;
    int            nd2;
    int            ne2;
    int            cyc;

    ddsl_link_if link();
    ddsl_link_if link2();

    ddsl_host u_ddsl_host (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid),
        .channel_addr_bit_in(req_addr), .power_down_bit_in(req_pd), .code_bits_in(req_code),
        .ready_out(ready), .done_out(done), .link(link));
    ddsl_device u_ddsl_device (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(link),
        .chan_a_code_out(a_code), .chan_b_code_out(b_code), .chan_a_update_out(a_upd),
        .chan_b_update_out(b_upd), .chan_a_oe_n_out(a_oe), .chan_b_oe_n_out(b_oe),
        .bz_ref_oe_n_out(bz_oe), .power_down_out(pd), .word_done_out(wdone),
        .zero_bit_err_out(err));
    ddsl_device u_ddsl_device_b (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(link2),
        .chan_a_code_out(c2a), .chan_b_code_out(c2b), .chan_a_update_out(),
        .chan_b_update_out(), .chan_a_oe_n_out(), .chan_b_oe_n_out(), .bz_ref_oe_n_out(),
        .power_down_out(), .word_done_out(wd2), .zero_bit_err_out(er2));
    ddsl_monitor u_ddsl_monitor (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .frame_sel_n(link.frame_sel_n), .sclk(link.sclk), .serial_in_line(link.serial_in_line),
        .chan_a_code_out(a_code), .chan_b_code_out(b_code), .chan_a_update_out(a_upd),
        .chan_b_update_out(b_upd), .chan_a_oe_n_out(a_oe), .chan_b_oe_n_out(b_oe),
        .bz_ref_oe_n_out(bz_oe), .power_down_out(pd), .word_done_out(wdone),
        .zero_bit_err_out(err));

    // clock
    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end

    // word seen on the wire, sampled on serial clock rise
    always @(posedge link.sclk)
        if (link.frame_sel_n === 1'b0)
            ww <= {ww[14:0], link.serial_in_line};

    // pulse counters of the second converter and run limit
    always @(posedge mclk_in)
    begin
        nd2 += int'(wd2 === 1'b1);
        ne2 += int'(er2 === 1'b1);
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            $display("wrong value at %0t: run limit reached", $time);
            end_sim;
        end
    end

    task chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task end_sim;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task t_reset;
        @(posedge mclk_in);
        reset_n_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        @(negedge mclk_in);
        chk(a_code === 12'h800 && b_code === 12'h800 && pd === 1'b0, "reset");
        chk({a_oe, b_oe, bz_oe} === 3'b000, "reset enables");
    endtask : t_reset

    // one word through the host, then the wire is judged
    task automatic send(input logic a, input logic s, input ddsl_code_type c);
        int k;
        @(posedge mclk_in);
        req_valid <= 1'b1;
        req_addr  <= a;
        req_pd    <= s;
        req_code  <= c;
        @(posedge mclk_in);
        req_valid <= 1'b0;
        @(negedge mclk_in);
        chk(ready === 1'b0 && link.frame_sel_n === 1'b0, "frame start");
        k = 0;
        while (done !== 1'b1 && k < 200)
        begin
            @(negedge mclk_in);
            k++;
        end
        chk(k < 200, "no done");
        chk(ww === {a, 1'b0, s, 1'b0, c}, "wire word");
        chk(link.frame_sel_n === 1'b1 && link.sclk === 1'b0 && ready === 1'b1,
            "idle wires");
    endtask : send

    task t_channels;
        send(1'b0, 1'b0, 12'hfff);
        chk(a_code === 12'hfff && b_code === 12'h800, "channel a");
        send(1'b1, 1'b0, 12'h000);
        chk(b_code === 12'h000 && a_code === 12'hfff, "channel b");
    endtask : t_channels

    task t_shutdown;
        send(1'b0, 1'b1, 12'h5a5);
        chk(pd === 1'b1 && {a_oe, b_oe, bz_oe} === 3'b111, "shutdown");
        chk(a_code === 12'h5a5, "code in shutdown");
        send(1'b1, 1'b0, 12'h3c3);
        chk(pd === 1'b1 && b_code === 12'h3c3, "other address");
        send(1'b0, 1'b0, 12'h0f0);
        chk(pd === 1'b0 && {a_oe, b_oe, bz_oe} === 3'b000, "resume");
        // shutdown owned by address one this time
        send(1'b1, 1'b1, 12'h111);
        chk(pd === 1'b1 && b_code === 12'h111 && a_code === 12'h0f0, "shutdown b");
        send(1'b0, 1'b0, 12'h222);
        chk(pd === 1'b1 && a_code === 12'h222, "address zero keeps");
        send(1'b1, 1'b0, 12'h333);
        chk(pd === 1'b0 && b_code === 12'h333, "address one clears");
    endtask : t_shutdown

    // raw bits on the second link, data flipped while clock high
    task automatic shift2(input ddsl_word_type w, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk_in);
            link2.serial_in_line <= w[15-i];
            @(posedge mclk_in);
            link2.sclk <= 1'b1;
            @(posedge mclk_in);
            link2.serial_in_line <= ~w[15-i];
            @(posedge mclk_in);
            link2.sclk <= 1'b0;
        end
    endtask : shift2

    task fs2(input logic v);
        @(posedge mclk_in);
        link2.frame_sel_n <= v;
        @(posedge mclk_in);
    endtask : fs2

    task t_faults;
        shift2(16'hffff, 16);
        fs2(1'b0);
        shift2(16'h1abc, 15);
        fs2(1'b1);
        chk(nd2 == 0 && c2a === 12'h800, "partial frame");
        fs2(1'b0);
        shift2(16'h1abc, 16);
        shift2(16'hffff, 8);
        @(negedge mclk_in);
        chk(nd2 == 1 && ne2 == 1 && c2a === 12'habc, "frame load");
        chk(c2b === 12'h800, "other channel");
        fs2(1'b1);
    endtask : t_faults

    // main sequence
    initial
    begin
        reset_n_in = 1'b0;
        req_valid = 1'b0;
        req_addr = 1'b0;
        req_pd = 1'b0;
        req_code = 12'h000;
        link2.frame_sel_n = 1'b1;
        link2.sclk = 1'b0;
        link2.serial_in_line = 1'b0;
        t_reset;
        t_channels;
        t_shutdown;
        t_faults;
        send(1'b1, 1'b1, 12'h111);
        chk(pd === 1'b1 && {a_oe, b_oe, bz_oe} === 3'b111, "shutdown before reset");
        t_reset;
        end_sim;
    end
endmodule : dual_dac_serial_word_loader_test
